// >>> dtc_consts.svh
// constants and register map for the dual timer/counter block
// Function
// - timer1 counter-select bit makes timer1 count external events
// - timer1 mode field: 0 12-bit, 1 16-bit, 2 reload, 3 split
// - timer0 mode field in low bits uses the same four-value encoding
// - timer0 run and gate set: count only while irq0 pin is high
// - timer0 gate clear and run set: count regardless of irq0 pin
// - timer0 counter-select bit makes timer0 count external events
// - count bytes are software read/write, reset to zero
// - 12-bit mode count is seven high-byte bits and five low-byte bits
// - 12-bit mode leaves high-byte top bit and low-byte top three bits
// - timer0 12-bit overflow sets the timer0 overflow flag
// - timer1 12-bit mode works like timer0 with its own bytes and flag
// - 16-bit mode uses all bits of both bytes as one counter
// - reload mode: low byte counts, reloaded from high byte on overflow
// - reload mode overflow sets flag; high byte stays unchanged
// - timer1 reload mode works like timer0
// - split mode: timer0 low byte uses timer0 run, gate and select
// - split mode: timer0 high byte runs on timer1 run bit, sets flag1
// - while timer0 is split, timer1 stops and holds its count
// - each timer counts only while its own run bit is one, except the split timer0 high byte (timer1 run bit); run resets zero
// - timer1 run and gate set: count only while irq1 pin is high
// - set flag requests interrupt; service acknowledge clears it
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

// register indices; byte address is four times the index
`define DTC_IDX_CTRL   10'h088
`define DTC_IDX_MODE   10'h089
`define DTC_IDX_TL0    10'h08A
`define DTC_IDX_TL1    10'h08B
`define DTC_IDX_TH0    10'h08C
`define DTC_IDX_TH1    10'h08D

// mode register fields
`define DTC_T1_GATE    7
`define DTC_T1_CS      6
`define DTC_T1_MODE_HI 5
`define DTC_T1_MODE_LO 4
`define DTC_T0_GATE    3
`define DTC_T0_CS      2
`define DTC_T0_MODE_HI 1
`define DTC_T0_MODE_LO 0

// control register fields
`define DTC_TF1        7
`define DTC_TR1        6
`define DTC_TF0        5
`define DTC_TR0        4

`define DTC_RST_BYTE   8'h00
`define DTC_RESP_OKAY  2'h0
`define DTC_RESP_SLVERR 2'h2

// timer tick every DTC_PRESCALE clocks
`define DTC_PRESCALE   4'hC
`define DTC_PRESC_LAST (`DTC_PRESCALE - 4'h1)

`endif

// >>> dtc_count_src.sv
// count enable source for one timer: run, gate and tick selection
`timescale 1ns/1ns
module dtc_count_src (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic count_pin,
  input  wire logic counter_select,
  input  wire logic run_bit,
  input  wire logic gate_control,
  input  wire logic gate_pin,
  input  wire logic prescale_tick,
  output logic      count_inc
);
  import dtc_pkg::*;

  logic prev_q;
  logic fall;
  logic enabled;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= count_pin;
    end
  end

  assign fall = prev_q & ~count_pin;

  // gate only matters when the gate control bit is set
  assign enabled = run_bit & (~gate_control | gate_pin);

  // event counting versus divided system clock
  assign count_inc = enabled & (counter_select ? fall : prescale_tick);

endmodule : dtc_count_src

// >>> dtc_pkg.sv
// types for the dual timer/counter block
package dtc_pkg;

  typedef enum logic [1:0] {
    DTC_MODE_12BIT,
    DTC_MODE_16BIT,
    DTC_MODE_RELOAD,
    DTC_MODE_SPLIT
  } dtc_mode_type;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
    logic       ovf;
  } dtc_cnt_type;

endpackage : dtc_pkg

// >>> dtc_timer_top.sv
// dual timer/counter with axi4-lite register access
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
`include "dtc_consts.svh"
module dtc_timer_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ext_irq0_pin,
  input  wire logic        ext_irq1_pin,
  input  wire logic        ext_count0_pin,
  input  wire logic        ext_count1_pin,
  input  wire logic        isr0_ack,
  input  wire logic        isr1_ack,
  output logic             timer0_irq,
  output logic             timer1_irq
);
  import dtc_pkg::*;

  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [7:0]  tl0_q;
  logic [7:0]  th0_q;
  logic [7:0]  tl1_q;
  logic [7:0]  th1_q;
  logic [7:0]  mode_q;
  logic        tr0_q;
  logic        tr1_q;
  logic        tf0_q;
  logic        tf1_q;
  logic [3:0]  presc_q;

  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    return a[11:2] == idx;
  endfunction : hit

  function automatic logic mapped(input logic [11:0] a);
    return (a[11:2] >= `DTC_IDX_CTRL) && (a[11:2] <= `DTC_IDX_TH1);
  endfunction : mapped

  function automatic logic [7:0] read_byte(input logic [11:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a[11:2])
      `DTC_IDX_CTRL: r = {tf1_q, tr1_q, tf0_q, tr0_q, 4'h0};
      `DTC_IDX_MODE: r = mode_q;
      `DTC_IDX_TL0:  r = tl0_q;
      `DTC_IDX_TL1:  r = tl1_q;
      `DTC_IDX_TH0:  r = th0_q;
      `DTC_IDX_TH1:  r = th1_q;
      default:       r = 8'h00;
    endcase
    return r;
  endfunction : read_byte

  // one count step for modes 0..2; split uses the low byte as 8-bit
  function automatic dtc_cnt_type step(input dtc_mode_type m,
                                       input logic [7:0]   hi,
                                       input logic [7:0]   lo);
    dtc_cnt_type r;
    logic [11:0] c12;
    logic [15:0] c16;
    r.hi = hi;
    r.lo = lo;
    r.ovf = 1'b0;
    c12 = {hi[6:0], lo[4:0]} + 12'h001;
    c16 = {hi, lo} + 16'h0001;
    case (m)
      DTC_MODE_12BIT: begin
        r.hi = {hi[7], c12[11:5]};
        r.lo = {lo[7:5], c12[4:0]};
        r.ovf = &{hi[6:0], lo[4:0]};
      end
      DTC_MODE_16BIT: begin
        r.hi = c16[15:8];
        r.lo = c16[7:0];
        r.ovf = &{hi, lo};
      end
      DTC_MODE_RELOAD: begin
        r.ovf = &lo;
        r.lo = r.ovf ? hi : lo + 8'h01;
      end
      default: begin
        r.ovf = &lo;
        r.lo = lo + 8'h01;
      end
    endcase
    return r;
  endfunction : step

  // write path
  logic wr_fire;
  logic wr_lane;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_tl0;
  logic wr_th0;
  logic wr_tl1;
  logic wr_th1;
  logic [7:0] wbyte;

  assign wr_fire = ~awready_q & ~wready_q & ~bvalid_q;
  assign wr_lane = wr_fire & wstrb_q[0];
  assign wbyte   = wdata_q[7:0];
  assign wr_ctrl = wr_lane & hit(awaddr_q, `DTC_IDX_CTRL);
  assign wr_mode = wr_lane & hit(awaddr_q, `DTC_IDX_MODE);
  assign wr_tl0  = wr_lane & hit(awaddr_q, `DTC_IDX_TL0);
  assign wr_th0  = wr_lane & hit(awaddr_q, `DTC_IDX_TH0);
  assign wr_tl1  = wr_lane & hit(awaddr_q, `DTC_IDX_TL1);
  assign wr_th1  = wr_lane & hit(awaddr_q, `DTC_IDX_TH1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      awaddr_q  <= 12'h000;
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      awaddr_q  <= s_axi_awaddr;
    end else if (wr_fire) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_fire) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `DTC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= mapped(awaddr_q) ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `DTC_RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= {24'h00_0000, read_byte(s_axi_araddr)};
      rresp_q   <= mapped(s_axi_araddr) ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // tick source for timer mode
  logic presc_tick;
  assign presc_tick = presc_q == `DTC_PRESC_LAST;

  always_ff @(posedge aclk) begin
    if (!aresetn || presc_tick) begin
      presc_q <= 4'h0;
    end else begin
      presc_q <= presc_q + 4'h1;
    end
  end

  // per-timer count enables
  logic [1:0] inc_v;
  logic [1:0] run_v;
  logic [1:0] gate_v;
  logic [1:0] cs_v;
  logic [1:0] pin_v;
  logic [1:0] gpin_v;

  assign run_v  = {tr1_q, tr0_q};
  assign gate_v = {mode_q[`DTC_T1_GATE], mode_q[`DTC_T0_GATE]};
  assign cs_v   = {mode_q[`DTC_T1_CS], mode_q[`DTC_T0_CS]};
  assign pin_v  = {ext_count1_pin, ext_count0_pin};
  assign gpin_v = {ext_irq1_pin, ext_irq0_pin};

  for (genvar gi = 0; gi < 2; gi++) begin : g_src
    dtc_count_src u_src (
      .aclk           (aclk),
      .aresetn        (aresetn),
      .count_pin      (pin_v[gi]),
      .counter_select (cs_v[gi]),
      .run_bit        (run_v[gi]),
      .gate_control   (gate_v[gi]),
      .gate_pin       (gpin_v[gi]),
      .prescale_tick  (presc_tick),
      .count_inc      (inc_v[gi])
    );
  end

  dtc_mode_type m0;
  dtc_mode_type m1;
  dtc_cnt_type  nxt0;
  dtc_cnt_type  nxt1;
  logic         split;
  logic         inc_th0s;
  logic         inc1;
  logic         set0;
  logic         set1;

  assign m0 = dtc_mode_type'(mode_q[`DTC_T0_MODE_HI:`DTC_T0_MODE_LO]);
  assign m1 = dtc_mode_type'(mode_q[`DTC_T1_MODE_HI:`DTC_T1_MODE_LO]);
  assign nxt0 = step(m0, th0_q, tl0_q);
  assign nxt1 = step(m1, th1_q, tl1_q);
  assign split = m0 == DTC_MODE_SPLIT;
  assign inc_th0s = split & tr1_q & presc_tick;
  // timer1 in its own split setting also stands still
  assign inc1 = inc_v[1] & ~split & (m1 != DTC_MODE_SPLIT);
  assign set0 = inc_v[0] & nxt0.ovf & ~wr_tl0 & ~wr_th0;
  assign set1 = split ? (inc_th0s & (&th0_q) & ~wr_th0)
                      : (inc1 & nxt1.ovf & ~wr_tl1 & ~wr_th1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tl0_q <= `DTC_RST_BYTE;
    end else if (wr_tl0) begin
      tl0_q <= wbyte;
    end else if (inc_v[0]) begin
      tl0_q <= nxt0.lo;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      th0_q <= `DTC_RST_BYTE;
    end else if (wr_th0) begin
      th0_q <= wbyte;
    end else if (split) begin
      if (inc_th0s) begin
        th0_q <= th0_q + 8'h01;
      end
    end else if (inc_v[0]) begin
      th0_q <= nxt0.hi;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tl1_q <= `DTC_RST_BYTE;
      th1_q <= `DTC_RST_BYTE;
    end else begin
      if (wr_tl1) begin
        tl1_q <= wbyte;
      end else if (inc1) begin
        tl1_q <= nxt1.lo;
      end
      if (wr_th1) begin
        th1_q <= wbyte;
      end else if (inc1) begin
        th1_q <= nxt1.hi;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= `DTC_RST_BYTE;
    end else if (wr_mode) begin
      mode_q <= wbyte;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tr0_q <= 1'b0;
      tr1_q <= 1'b0;
    end else if (wr_ctrl) begin
      tr0_q <= wbyte[`DTC_TR0];
      tr1_q <= wbyte[`DTC_TR1];
    end
  end

  // hardware set beats software clear and service acknowledge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tf0_q <= 1'b0;
      tf1_q <= 1'b0;
    end else begin
      if (set0) begin
        tf0_q <= 1'b1;
      end else if (wr_ctrl) begin
        tf0_q <= wbyte[`DTC_TF0];
      end else if (isr0_ack) begin
        tf0_q <= 1'b0;
      end
      if (set1) begin
        tf1_q <= 1'b1;
      end else if (wr_ctrl) begin
        tf1_q <= wbyte[`DTC_TF1];
      end else if (isr1_ack) begin
        tf1_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign timer0_irq    = tf0_q;
  assign timer1_irq    = tf1_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_run_hold: assert property (
    !tr0_q && !wr_tl0 |=> $stable(tl0_q))
    else $error("timer0 low byte moved with run bit clear");

  a_gate_block: assert property (
    tr0_q && mode_q[`DTC_T0_GATE] && !ext_irq0_pin && !wr_tl0
    |=> $stable(tl0_q))
    else $error("timer0 counted while gate pin low");

  a_free_select: assert property (
    tr0_q && mode_q[`DTC_T0_CS] && !mode_q[`DTC_T0_GATE]
    && !$fell(ext_count0_pin) && !wr_tl0 |=> $stable(tl0_q))
    else $error("timer0 counter moved without an input edge");

  a_split_hold: assert property (
    split && !wr_tl1 && !wr_th1 |=> $stable({th1_q, tl1_q}))
    else $error("timer1 moved while timer0 split");

  a_reload_lo: assert property (
    m0 == DTC_MODE_RELOAD && inc_v[0] && tl0_q == 8'hFF
    && !wr_tl0 && !wr_th0 |=> tl0_q == $past(th0_q))
    else $error("low byte not reloaded from high byte");

  a_reload_flag: assert property (
    m0 == DTC_MODE_RELOAD && inc_v[0] && tl0_q == 8'hFF
    && !wr_tl0 && !wr_th0 |=> tf0_q && $stable(th0_q))
    else $error("reload overflow flag or high byte wrong");

  a_mode1_incr: assert property (
    m0 == DTC_MODE_16BIT && inc_v[0] && !wr_tl0 && !wr_th0
    |=> {th0_q, tl0_q} == $past({th0_q, tl0_q}) + 16'h0001)
    else $error("16-bit count did not advance by one");

  a_mode0_wrap: assert property (
    m0 == DTC_MODE_12BIT && inc_v[0] && th0_q[6:0] == 7'h7F
    && tl0_q[4:0] == 5'h1F && !wr_tl0 && !wr_th0
    |=> tf0_q && th0_q[6:0] == 7'h00 && tl0_q[4:0] == 5'h00)
    else $error("12-bit wrap wrong");

  a_mode0_unused: assert property (
    m0 == DTC_MODE_12BIT && !wr_tl0 && !wr_th0
    |=> $stable(th0_q[7]) && $stable(tl0_q[7:5]))
    else $error("ignored 12-bit mode bits changed");

  a_split_high: assert property (
    split && tr1_q && presc_tick && th0_q == 8'hFF && !wr_th0
    |=> tf1_q && th0_q == 8'h00)
    else $error("split high byte overflow did not set flag1");

  a_sw_write: assert property (
    wr_tl0 |=> tl0_q == $past(wdata_q[7:0]))
    else $error("write to timer0 low byte lost");

  a_ack_clear: assert property (
    isr0_ack && !set0 && !wr_ctrl |=> !timer0_irq)
    else $error("acknowledge did not clear timer0 flag");

  a_bus_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready)
    else $error("read not answered in one cycle");

  c_reload: cover property (m0 == DTC_MODE_RELOAD && set0);
  c_split_flag: cover property (split && set1);
  c_mode0_ovf: cover property (m0 == DTC_MODE_12BIT && set0);
  c_read_done: cover property (s_axi_rvalid && s_axi_rready);

endmodule : dtc_timer_top

// >>> dual_timer_counter_modes_test.sv
// randomised self-checking bench for the dual timer/counter
`timescale 1ns/1ns
`include "dtc_consts.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module dual_timer_counter_modes_test;
  import dtc_pkg::*;
  logic        aclk;
  logic        aresetn;
  logic [11:0] s_axi_awaddr;
  logic [11:0] s_axi_araddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [31:0] s_axi_wdata;
  logic [31:0] s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [1:0]  irq_pin;
  logic [1:0]  cnt_pin;
  logic [1:0]  ack;
  logic        timer0_irq;
  logic        timer1_irq;
  logic [31:0] seed = 32'h24C4;
  logic [31:0] rdat;
  logic [1:0]  rsp_r;
  logic [1:0]  rsp_b;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cyc = 0;

  dtc_timer_top dtc_timer_top_i (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .s_axi_awaddr   (s_axi_awaddr),
    .s_axi_awvalid  (s_axi_awvalid),
    .s_axi_awready  (s_axi_awready),
    .s_axi_wdata    (s_axi_wdata),
    .s_axi_wstrb    (s_axi_wstrb),
    .s_axi_wvalid   (s_axi_wvalid),
    .s_axi_wready   (s_axi_wready),
    .s_axi_bresp    (s_axi_bresp),
    .s_axi_bvalid   (s_axi_bvalid),
    .s_axi_bready   (s_axi_bready),
    .s_axi_araddr   (s_axi_araddr),
    .s_axi_arvalid  (s_axi_arvalid),
    .s_axi_arready  (s_axi_arready),
    .s_axi_rdata    (s_axi_rdata),
    .s_axi_rresp    (s_axi_rresp),
    .s_axi_rvalid   (s_axi_rvalid),
    .s_axi_rready   (s_axi_rready),
    .ext_irq0_pin   (irq_pin[0]),
    .ext_irq1_pin   (irq_pin[1]),
    .ext_count0_pin (cnt_pin[0]),
    .ext_count1_pin (cnt_pin[1]),
    .isr0_ack       (ack[0]),
    .isr1_ack       (ack[1]),
    .timer0_irq     (timer0_irq),
    .timer1_irq     (timer1_irq)
  );

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task finish_test();
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // hang guard, far above the expected run length
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // expected {flag, high, low} after n counts in mode m
  function automatic logic [16:0] model(int m, logic [7:0] hi, lo, int n);
    logic        f;
    logic [11:0] c;
    f = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (m == 0) begin
        if ({hi[6:0], lo[4:0]} == 12'hFFF) f = 1'b1;
        c = {hi[6:0], lo[4:0]} + 12'h001;
        hi[6:0] = c[11:5];
        lo[4:0] = c[4:0];
      end else if (m == 1) begin
        if ({hi, lo} == 16'hFFFF) f = 1'b1;
        {hi, lo} = {hi, lo} + 16'h0001;
      end else begin
        if (lo == 8'hFF) f = 1'b1;
        lo = (lo == 8'hFF) ? hi : lo + 8'h01;
      end
    end
    return {f, hi, lo};
  endfunction : model

  // waits for the answer however long it takes; only the hang guard ends it
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    rsp_b = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [9:0] idx);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    rdat = s_axi_rdata;
    rsp_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // one falling edge per pulse on the selected count pins
  task automatic pulse(input logic [1:0] mask, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      cnt_pin <= mask;
      @(posedge aclk);
      cnt_pin <= 2'b00;
    end
    @(posedge aclk);
  endtask : pulse

  initial begin
    int          k;
    int          n;
    logic [31:0] x;
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [7:0]  md;
    logic [9:0]  ih;
    logic [9:0]  il;
    logic        g;
    logic        run;
    logic [16:0] e;
    aresetn = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    irq_pin = 2'b00;
    cnt_pin = 2'b00;
    ack = 2'b00;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(`DTC_IDX_CTRL + 10'(i));
      `CHK("reset_val", 32'h0, rdat);
    end
    rd(10'h090);
    `CHK("unmapped_rd", `DTC_RESP_SLVERR, rsp_r);
    wr(10'h090, 8'hFF);
    `CHK("unmapped_wr", `DTC_RESP_SLVERR, rsp_b);
    // lane 0 strobe low: acknowledged but ignored
    s_axi_wstrb <= 4'hE;
    wr(`DTC_IDX_TL0, 8'h5A);
    `CHK("strb_resp", `DTC_RESP_OKAY, rsp_b);
    s_axi_wstrb <= 4'hF;
    rd(`DTC_IDX_TL0);
    `CHK("strb_ignored", 32'h0, rdat);
    for (int i = 0; i < 8; i++) begin
      x = rnd();
      il = `DTC_IDX_TL0 + 10'(i % 4);
      wr(il, x[7:0]);
      rd(il);
      `CHK("count_byte", {24'h0, x[7:0]}, rdat);
      `CHK("wr_resp", `DTC_RESP_OKAY, rsp_b);
      `CHK("rd_resp", `DTC_RESP_OKAY, rsp_r);
    end
    for (int t = 0; t < 2; t++) begin
      for (int m = 0; m < 3; m++) begin
        for (int r = 0; r < 4; r++) begin
          x = rnd();
          hi = (r == 0) ? ((m == 2) ? 8'h40 : 8'hFF) : x[7:0];
          lo = (r == 0) ? 8'hFE : x[15:8];
          g = (r != 0) && x[16];
          run = (r != 3);
          n = (r == 0) ? 3 : 1 + int'(x[20:18]) % 6;
          e = model(m, hi, lo, (run && !(g && !x[17])) ? n : 0);
          md = t ? {g, 1'b1, 2'(m), 4'h0} : {4'h0, g, 1'b1, 2'(m)};
          il = t ? `DTC_IDX_TL1 : `DTC_IDX_TL0;
          ih = t ? `DTC_IDX_TH1 : `DTC_IDX_TH0;
          wr(`DTC_IDX_CTRL, 8'h00);
          wr(`DTC_IDX_MODE, md);
          wr(il, lo);
          wr(ih, hi);
          irq_pin <= t ? {x[17], 1'b0} : {1'b0, x[17]};
          wr(`DTC_IDX_CTRL, run ? (t ? 8'h40 : 8'h10) : 8'h00);
          pulse(t ? 2'b10 : 2'b01, n);
          rd(`DTC_IDX_MODE);
          `CHK("mode_reg", {24'h0, md}, rdat);
          rd(il);
          `CHK("low", {24'h0, e[7:0]}, rdat);
          rd(ih);
          `CHK("high", {24'h0, e[15:8]}, rdat);
          `CHK("flag", e[16], t ? timer1_irq : timer0_irq);
          ack <= t ? 2'b10 : 2'b01;
          @(posedge aclk);
          ack <= 2'b00;
          repeat (2) @(posedge aclk);
          `CHK("flag_ack", 1'b0, t ? timer1_irq : timer0_irq);
        end
      end
    end
    // split mode: timer1 set to count its pin, so any change is a fault
    wr(`DTC_IDX_CTRL, 8'h00);
    wr(`DTC_IDX_MODE, {6'h15, DTC_MODE_SPLIT});
    wr(`DTC_IDX_TL1, 8'h55);
    wr(`DTC_IDX_TH1, 8'h66);
    wr(`DTC_IDX_TL0, 8'hFE);
    wr(`DTC_IDX_TH0, 8'hFF);
    irq_pin <= 2'b00;
    wr(`DTC_IDX_CTRL, 8'h10);
    pulse(2'b11, 3);
    `CHK("split_f0", 1'b1, timer0_irq);
    `CHK("split_f1", 1'b0, timer1_irq);
    rd(`DTC_IDX_TL0);
    `CHK("split_low", 32'h01, rdat);
    wr(`DTC_IDX_CTRL, 8'h70);
    for (k = 0; k < 30 && timer1_irq !== 1'b1; k++) @(posedge aclk);
    `CHK("split_f1_set", 1'b1, timer1_irq);
    rd(`DTC_IDX_TH0);
    `CHK("split_high", 32'h00, rdat);
    rd(`DTC_IDX_TL1);
    `CHK("t1_low_hold", 32'h55, rdat);
    rd(`DTC_IDX_TH1);
    `CHK("t1_high_hold", 32'h66, rdat);
    // read lands midway between the fourth and fifth tick
    repeat (42) @(posedge aclk);
    rd(`DTC_IDX_TH0);
    `CHK("tick_rate", 32'h04, rdat);
    // internal ticks: run spans 120 clocks, a whole number of tick periods
    wr(`DTC_IDX_CTRL, 8'h00);
    wr(`DTC_IDX_MODE, 8'h11);
    for (int i = 0; i < 4; i++) wr(`DTC_IDX_TL0 + 10'(i), 8'h00);
    wr(`DTC_IDX_CTRL, 8'h50);
    repeat (116) @(posedge aclk);
    wr(`DTC_IDX_CTRL, 8'h00);
    rd(`DTC_IDX_TL0);
    `CHK("tick_t0", 120 / `DTC_PRESCALE, rdat);
    rd(`DTC_IDX_TL1);
    `CHK("tick_t1", 120 / `DTC_PRESCALE, rdat);
    // second reset in mid-run clears a nonzero count byte
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`DTC_IDX_TL0);
    `CHK("reset_mid", 32'h0, rdat);
    finish_test();
  end
endmodule : dual_timer_counter_modes_test
